// *** seq_pkg.sv ***
// Purpose: Shared constants and types of the regulator sequencer.
// Assumes: 25 MHz core clock stands in for the timing reference.
// Notes: Register indices are word indices on the plain register port.
package seq_pkg;
  localparam int CLK_HZ = 25000000;
  // Restart hold-off after shutdown, and calibration settle time
  localparam int RESTART_US = 2000;
  localparam int RESTART_CYC = (CLK_HZ / 1000000) * RESTART_US;
  localparam int CAL_SETTLE_US = 20;
  localparam int CAL_SETTLE_CYC = (CLK_HZ / 1000000) * CAL_SETTLE_US;
  // Divider and phase limits
  localparam logic [6:0] DIV_MIN = 7'h06;
  localparam logic [6:0] DIV_MAX = 7'h7F;
  localparam logic [2:0] NPH_MIN = 3'h1;
  localparam logic [2:0] NPH_MAX = 3'h6;
  // Current ADC: 6-bit code, 4.3 uA per step, 275 uA span
  localparam int CUR_STEP_NA = 4300;
  localparam int CUR_SPAN_NA = 275000;
  localparam int CUR_BITS = 6;
  // Configuration store
  localparam logic [2:0] CFG_WORDS = 3'h5;
  // Register indices
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_FREQ = 4'h1;
  localparam logic [3:0] REG_RATE = 4'h2;
  localparam logic [3:0] REG_CALIB = 4'h3;
  localparam logic [3:0] REG_FMASK = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_FAULT = 4'h6;
  localparam logic [3:0] REG_VFILT = 4'h7;
  localparam logic [3:0] REG_TARGET = 4'h8;
  localparam logic [3:0] REG_PHASE0 = 4'h9;
  // Control field positions
  localparam int CTRL_UVLO = 0;
  localparam int CTRL_CAL = 1;
  localparam int CTRL_LATCH = 2;
  localparam int CTRL_SENSE = 3;
  localparam int CTRL_STAGE_DEF = 5;
  localparam int CTRL_GOOD_DEF = 7;
  // Reset values
  localparam logic [8:0] CTRL_RST = 9'h001;
  localparam logic [10:0] FREQ_RST = 11'h31A;
  localparam logic [15:0] RATE_RST = 16'h0404;
  localparam logic [15:0] CALIB_RST = 16'h2020;
  localparam logic [3:0] FMASK_RST = 4'hF;
  // Default output levels in the inactive state
  localparam logic [1:0] DEF_LOW = 2'h0;
  localparam logic [1:0] DEF_HIGH = 2'h1;
  typedef enum logic [2:0] {
    ST_CONFIG, ST_INACTIVE, ST_SOFTSTART, ST_CAL, ST_ACTIVE, ST_SHUTDOWN, ST_RESTART
  } seq_state_type;
endpackage : seq_pkg

// *** switch_timer.sv ***
// Purpose: Switching-cycle framing: voltage sample ticks, phase order, current ADC mux.
// Assumes: div_sel and nph are already clamped to their legal ranges.
// Notes: Two sample ticks per phase; the current sample sits mid-phase.
module switch_timer
  import seq_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // Setup
  input wire logic run_in,
  input wire logic [6:0] div_sel_in,
  input wire logic [2:0] nph_in,
  // Timing
  output logic sample_tick_out,
  output logic cycle_start_out,
  output logic cur_strobe_out,
  output logic [2:0] cur_sel_out
);
  typedef struct packed {
    logic [6:0] cnt;
    logic half;
    logic [2:0] ph;
    logic tick;
    logic cyc;
    logic cstb;
    logic [2:0] csel;
  } tmr_type;

  tmr_type q, d;

  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    d.cyc = 1'b0;
    d.cstb = 1'b0;
    if (!run_in)
    begin
      d.cnt = 7'h00;
      d.half = 1'b0;
      d.ph = 3'h0;
    end
    else if (q.cnt >= div_sel_in - 7'h01)
    begin
      // Sample rate is the reference over div_sel
      d.cnt = 7'h00;
      d.tick = 1'b1;
      d.half = ~q.half;
      if (!q.half)
      begin
        d.cstb = 1'b1;
        d.csel = q.ph;
      end
      else if (q.ph >= nph_in - 3'h1)
      begin
        // Cycle spans 2 x div_sel x nph reference ticks
        d.ph = 3'h0;
        d.cyc = 1'b1;
      end
      else
        d.ph = q.ph + 3'h1;
    end
    else
      d.cnt = q.cnt + 7'h01;
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      q <= '0;
    else
      q <= d;
  end

  assign sample_tick_out = q.tick;
  assign cycle_start_out = q.cyc;
  assign cur_strobe_out = q.cstb;
  assign cur_sel_out = q.csel;
endmodule : switch_timer

// *** reg_sequencer.sv ***
// Purpose: Power-up, soft-start, calibration, regulation and shutdown sequencing.
// Assumes: All inputs except ext_rst_n_in synchronous to mclk_in; loop width comes from the outer loop.
// Notes: Registers sit on a plain port with read data one cycle after the strobe.
// Behaviour
// - Configuration starts on power-on reset or the external reset.
// - Configuration copies stored words into the working registers.
// - All outputs released to high impedance while configuring.
// - Inactive state drives each output to its configured low, high or off level.
// - Register access and fault reporting stay alive while inactive.
// - Start needs valid code, enable asserted and supply valid.
// - Supply comparator gates start only when lockout is enabled.
// - Soft-start raises the target monotonically from zero to the setpoint.
// - Optional calibration measures each phase with and without a known load.
// - End of ramp enters regulation and raises the output-good flag.
// - Enable low, all-ones code or a shutdown fault start shutdown.
// - Shutdown shrinks pulse width at a set rate, then releases the stage.
// - After shutdown a fixed hold-off precedes the return to inactive.
// - A latched fault holds the regulator off until enable or reset toggles.
// - Switching cycle equals reference over twice divider times phase count.
// - Divider accepted 6 to 127, phases 1 to 6.
// - Switching rate set by configuration only, never by load.
// - Voltage samples twice per phase per cycle, reference over divider.
// - Voltage samples pass a post-filter nulling the ripple frequency.
// - Current ADC yields 6-bit codes of 4.3 uA over 275 uA.
// - Three selectable sense methods share one multiplexed current ADC.
// - External reset is active low and asynchronous.
//
// Chosen here: the register addresses and the address-and-strobe port.
module reg_sequencer
  import seq_pkg::*;
#(
  parameter int RESTART_CYCLES = RESTART_CYC,
  parameter int PHASES = 6
)
(
  // Clock and resets
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic ext_rst_n_in,
  // Register port
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // Configuration store
  output logic [2:0] config_store_addr_out,
  input wire logic [15:0] config_store_data_in,
  // Regulator control
  input wire logic regulator_enable_in,
  input wire logic [7:0] voltage_code_in,
  input wire logic code_valid_in,
  input wire logic supply_ok_in,
  input wire logic [3:0] fault_in,
  // Converters and loop
  input wire logic [7:0] vadc_in,
  input wire logic [CUR_BITS-1:0] cur_code_in,
  input wire logic [7:0] loop_width_in,
  // Power stage and status pins
  output logic stage_oe_out,
  output logic stage_level_out,
  output logic [7:0] width_out,
  output logic [7:0] target_out,
  output logic output_good_flag_out,
  output logic good_oe_out,
  output logic [2:0] state_out,
  // Sensing and calibration
  output logic sample_tick_out,
  output logic [2:0] cur_sel_out,
  output logic [1:0] sense_mode_out,
  output logic cal_load_out,
  output logic [7:0] cal_current_out
);
  typedef struct packed {
    seq_state_type st;
    logic [2:0] cfg_idx;
    logic [8:0] ctrl;
    logic [10:0] freq;
    logic [15:0] rate;
    logic [15:0] calib;
    logic [3:0] fmask;
    logic [3:0] fault;
    logic latched;
    logic cal_done;
    logic [1:0] cal_step;
    logic [2:0] cal_ph;
    logic [7:0] target;
    logic [7:0] width;
    logic [7:0] pre;
    logic [15:0] dly;
    logic [PHASES-1:0][CUR_BITS-1:0] offs;
    logic [PHASES-1:0][CUR_BITS-1:0] gain;
    logic [3:0][7:0] vhist;
    logic [9:0] vfilt;
    logic [15:0] rdata;
    logic stage_oe;
    logic stage_lvl;
    logic good;
    logic good_oe;
    logic cal_load;
    logic tick;
    logic [2:0] csel;
  } seq_type;

  seq_type q, d;
  logic [6:0] div_eff;
  logic [2:0] nph_eff;
  logic run;
  logic s_tick;
  logic c_strobe;
  logic [2:0] c_sel;
  logic in_ok;
  logic go;
  logic stop;
  logic sd_fault;
  logic rtick;
  logic [CUR_BITS-1:0] delta;

  // Out-of-range settings are clamped rather than rejected
  always_comb
  begin
    div_eff = q.freq[6:0];
    nph_eff = q.freq[10:8];
    if (div_eff < DIV_MIN)
      div_eff = DIV_MIN;
    if (nph_eff < NPH_MIN)
      nph_eff = NPH_MIN;
    else if (nph_eff > NPH_MAX)
      nph_eff = NPH_MAX;
  end

  assign run = (q.st != ST_CONFIG);

  // Rate depends only on configuration, never on load
  switch_timer u_timer (
    .mclk_in(mclk_in),
    .reset_in(reset_in | ~ext_rst_n_in),
    .run_in(run),
    .div_sel_in(div_eff),
    .nph_in(nph_eff),
    .sample_tick_out(s_tick),
    .cycle_start_out(),
    .cur_strobe_out(c_strobe),
    .cur_sel_out(c_sel)
  );

  assign in_ok = supply_ok_in | ~q.ctrl[CTRL_UVLO];
  assign go = code_valid_in & regulator_enable_in & in_ok & ~q.latched;
  assign sd_fault = |(fault_in & q.fmask);
  assign stop = ~regulator_enable_in | (&voltage_code_in) | sd_fault;
  assign rtick = (q.pre == 8'h00);
  assign delta = (cur_code_in > q.offs[q.cal_ph]) ? cur_code_in - q.offs[q.cal_ph] : '0;

  always_comb
  begin
    d = q;
    d.tick = s_tick;
    d.csel = c_sel;
    // Shared prescaler paces both ramps
    if (rtick)
      d.pre = (q.st == ST_SHUTDOWN) ? q.rate[15:8] : q.rate[7:0];
    else
      d.pre = q.pre - 8'h01;
    // Ripple null: four-sample sum cancels fsw*nph/2
    if (s_tick)
    begin
      d.vhist = {q.vhist[2:0], vadc_in};
      d.vfilt = 10'(vadc_in) + 10'(q.vhist[0]) + 10'(q.vhist[1]) + 10'(q.vhist[2]);
    end
    // Sticky fault flags, write-one-to-clear, set wins
    if (wr_in && addr_in == REG_FAULT)
      d.fault = q.fault & ~wdata_in[3:0];
    d.fault = d.fault | fault_in;
    if (wr_in)
    begin
      unique case (addr_in)
        REG_CTRL: d.ctrl = wdata_in[8:0];
        REG_FREQ: d.freq = wdata_in[10:0];
        REG_RATE: d.rate = wdata_in;
        REG_CALIB: d.calib = wdata_in;
        REG_FMASK: d.fmask = wdata_in[3:0];
        default: ;
      endcase
    end
    // Enable low clears a latched fault
    if (!regulator_enable_in)
      d.latched = 1'b0;
    // Read data stands in the cycle after the strobe only
    d.rdata = 16'h0000;
    if (rd_in)
    begin
      if (addr_in >= REG_PHASE0 && addr_in < REG_PHASE0 + 4'(PHASES))
        d.rdata = 16'({q.gain[addr_in - REG_PHASE0], q.offs[addr_in - REG_PHASE0]});
      else
      begin
        unique case (addr_in)
          REG_CTRL: d.rdata = 16'(q.ctrl);
          REG_FREQ: d.rdata = 16'(q.freq);
          REG_RATE: d.rdata = q.rate;
          REG_CALIB: d.rdata = q.calib;
          REG_FMASK: d.rdata = 16'(q.fmask);
          REG_STATUS: d.rdata = 16'({q.latched, q.good, q.st});
          REG_FAULT: d.rdata = 16'(q.fault);
          REG_VFILT: d.rdata = 16'(q.vfilt);
          REG_TARGET: d.rdata = 16'(q.target);
          default: d.rdata = 16'h0000;
        endcase
      end
    end
    unique case (q.st)
      ST_CONFIG:
      begin
        // Pins released to the board resistors
        d.stage_oe = 1'b0;
        d.good_oe = 1'b0;
        d.good = 1'b0;
        if (q.cfg_idx != 3'h0)
        begin
          // Data arrives one cycle after its address
          unique case (q.cfg_idx - 3'h1)
            3'h0: d.ctrl = config_store_data_in[8:0];
            3'h1: d.freq = config_store_data_in[10:0];
            3'h2: d.rate = config_store_data_in;
            3'h3: d.calib = config_store_data_in;
            default: d.fmask = config_store_data_in[3:0];
          endcase
        end
        if (q.cfg_idx == CFG_WORDS)
          d.st = ST_INACTIVE;
        else
          d.cfg_idx = q.cfg_idx + 3'h1;
      end
      ST_INACTIVE:
      begin
        // Configured idle levels of the pins
        d.width = 8'h00;
        d.target = 8'h00;
        d.cal_done = 1'b0;
        d.cal_load = 1'b0;
        d.good = (q.ctrl[CTRL_GOOD_DEF+:2] == DEF_HIGH);
        d.good_oe = (q.ctrl[CTRL_GOOD_DEF+:2] <= DEF_HIGH);
        d.stage_lvl = (q.ctrl[CTRL_STAGE_DEF+:2] == DEF_HIGH);
        d.stage_oe = (q.ctrl[CTRL_STAGE_DEF+:2] <= DEF_HIGH);
        if (go)
        begin
          d.st = ST_SOFTSTART;
          d.stage_oe = 1'b1;
          d.stage_lvl = 1'b0;
          d.good = 1'b0;
          d.good_oe = 1'b1;
        end
      end
      ST_SOFTSTART, ST_CAL:
      begin
        d.width = loop_width_in;
        if (stop)
        begin
          d.st = ST_SHUTDOWN;
          d.cal_load = 1'b0;
          if (sd_fault && q.ctrl[CTRL_LATCH])
            d.latched = 1'b1;
        end
        else if (q.st == ST_SOFTSTART)
        begin
          if (q.ctrl[CTRL_CAL] && !q.cal_done && q.target >= q.calib[7:0])
          begin
            // Hold at the calibration voltage
            d.st = ST_CAL;
            d.cal_ph = 3'h0;
            d.cal_step = 2'h0;
            d.dly = 16'(CAL_SETTLE_CYC);
          end
          else if (q.target >= voltage_code_in)
          begin
            d.st = ST_ACTIVE;
            d.good = 1'b1;
          end
          else if (rtick)
            d.target = q.target + 8'h01;
        end
        else
        begin
          if (q.dly != 16'h0000)
            d.dly = q.dly - 16'h0001;
          else if (c_strobe && c_sel == q.cal_ph)
          begin
            // One phase at a time: offset unloaded, gain loaded
            if (q.cal_step == 2'h0)
            begin
              d.offs[q.cal_ph] = cur_code_in;
              d.cal_load = 1'b1;
              d.cal_step = 2'h1;
              d.dly = 16'(CAL_SETTLE_CYC);
            end
            else
            begin
              d.gain[q.cal_ph] = delta;
              d.cal_load = 1'b0;
              d.cal_step = 2'h0;
              d.dly = 16'(CAL_SETTLE_CYC);
              if (q.cal_ph >= nph_eff - 3'h1)
              begin
                d.cal_done = 1'b1;
                d.st = ST_SOFTSTART;
              end
              else
                d.cal_ph = q.cal_ph + 3'h1;
            end
          end
        end
      end
      ST_ACTIVE:
      begin
        d.width = loop_width_in;
        if (stop)
        begin
          d.st = ST_SHUTDOWN;
          d.good = 1'b0;
          if (sd_fault && q.ctrl[CTRL_LATCH])
            d.latched = 1'b1;
        end
      end
      ST_SHUTDOWN:
      begin
        d.good = 1'b0;
        // Steady width decrement avoids output undershoot
        if (q.width == 8'h00)
        begin
          d.stage_oe = 1'b0;
          d.st = ST_RESTART;
          d.dly = 16'(RESTART_CYCLES - 1);
        end
        else if (rtick)
          d.width = q.width - 8'h01;
      end
      ST_RESTART:
      begin
        // Hold-off caps the autonomous restart duty cycle
        if (q.dly == 16'h0000)
          d.st = ST_INACTIVE;
        else
          d.dly = q.dly - 16'h0001;
      end
      default: d.st = ST_CONFIG;
    endcase
  end

  // Either reset restarts configuration with pins released
  always_ff @(posedge mclk_in or negedge ext_rst_n_in)
  begin
    if (!ext_rst_n_in)
    begin
      q <= '0;
      q.st <= ST_CONFIG;
      q.ctrl <= CTRL_RST;
      q.freq <= FREQ_RST;
      q.rate <= RATE_RST;
      q.calib <= CALIB_RST;
      q.fmask <= FMASK_RST;
    end
    else if (reset_in)
    begin
      q <= '0;
      q.st <= ST_CONFIG;
      q.ctrl <= CTRL_RST;
      q.freq <= FREQ_RST;
      q.rate <= RATE_RST;
      q.calib <= CALIB_RST;
      q.fmask <= FMASK_RST;
    end
    else
      q <= d;
  end

  assign rdata_out = q.rdata;
  assign config_store_addr_out = q.cfg_idx;
  assign stage_oe_out = q.stage_oe;
  assign stage_level_out = q.stage_lvl;
  assign width_out = q.width;
  assign target_out = q.target;
  assign output_good_flag_out = q.good;
  assign good_oe_out = q.good_oe;
  assign state_out = q.st;
  assign sample_tick_out = q.tick;
  assign cur_sel_out = q.csel;
  assign sense_mode_out = q.ctrl[CTRL_SENSE+:2];
  assign cal_load_out = q.cal_load;
  assign cal_current_out = q.calib[15:8];
endmodule : reg_sequencer

// *** reg_sequencer_chk_sva.sv ***
// Purpose: Port-level timing checks of the regulator sequencer.
// Assumes: State codes 0 configuring through 6 restart delay.
// Notes: The hold-off count follows the RESTART_CYCLES parameter.
module reg_sequencer_chk
  import seq_pkg::*;
#(
  parameter int RESTART_CYCLES = RESTART_CYC
)
(
  // Clock and resets
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic ext_rst_n_in,
  // Watched inputs
  input wire logic rd_in,
  input wire logic regulator_enable_in,
  input wire logic code_valid_in,
  input wire logic [7:0] voltage_code_in,
  // Watched outputs
  input wire logic [15:0] rdata_out,
  input wire logic stage_oe_out,
  input wire logic good_oe_out,
  input wire logic [7:0] width_out,
  input wire logic [7:0] target_out,
  input wire logic output_good_flag_out,
  input wire logic [2:0] state_out
);
  logic [31:0] hold_q;

  // Counts edges spent in the restart delay
  always_ff @(posedge mclk_in)
  begin
    if (reset_in || state_out != 3'h6)
      hold_q <= 32'h0;
    else
      hold_q <= hold_q + 32'h1;
  end

  default clocking dcb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in || !ext_rst_n_in);

  a_sync_reset_idle: assert property (disable iff (!ext_rst_n_in)
    reset_in |=> state_out == 3'h0 && !stage_oe_out) else $error("sync reset left outputs on");
  a_async_reset_idle: assert property (disable iff (reset_in)
    !ext_rst_n_in |-> state_out == 3'h0 && !stage_oe_out && !good_oe_out)
    else $error("external reset did not idle outputs");
  a_config_released: assert property (state_out == 3'h0 |-> !stage_oe_out && !good_oe_out)
    else $error("output driven while configuring");
  a_start_gated: assert property (state_out == 3'h1 && !(regulator_enable_in && code_valid_in)
    |=> state_out == 3'h1) else $error("start without enable and valid code");
  a_ramp_single_step: assert property (state_out == 3'h2 && $past(state_out) == 3'h2
    |-> target_out >= $past(target_out) && target_out <= $past(target_out) + 8'h01)
    else $error("soft-start target not monotonic");
  a_good_when_active: assert property (state_out == 3'h4 |-> output_good_flag_out)
    else $error("active without good flag");
  a_stop_on_enable: assert property ((state_out inside {3'h2, 3'h3, 3'h4}) &&
    !regulator_enable_in |=> state_out == 3'h5) else $error("enable low did not stop");
  a_stop_on_code: assert property ((state_out inside {3'h2, 3'h3, 3'h4}) &&
    voltage_code_in == 8'hFF |=> state_out == 3'h5) else $error("off code did not stop");
  a_width_falls: assert property (state_out == 3'h5 && $past(state_out) == 3'h5
    |-> width_out <= $past(width_out)) else $error("width grew in shutdown");
  a_stage_released: assert property (state_out == 3'h6 |-> !stage_oe_out && width_out == 8'h00)
    else $error("stage driven after shutdown");
  a_holdoff_exact: assert property ($fell(state_out == 3'h6) |->
    state_out == 3'h1 && hold_q == RESTART_CYCLES) else $error("restart delay length wrong");
  a_rdata_quiet: assert property (!$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("read data outside its cycle");
endmodule : reg_sequencer_chk

bind reg_sequencer reg_sequencer_chk #(.RESTART_CYCLES(RESTART_CYCLES)) i_reg_sequencer_chk (
  .mclk_in(mclk_in), .reset_in(reset_in), .ext_rst_n_in(ext_rst_n_in), .rd_in(rd_in),
  .regulator_enable_in(regulator_enable_in), .code_valid_in(code_valid_in),
  .voltage_code_in(voltage_code_in), .rdata_out(rdata_out), .stage_oe_out(stage_oe_out),
  .good_oe_out(good_oe_out), .width_out(width_out), .target_out(target_out),
  .output_good_flag_out(output_good_flag_out), .state_out(state_out));

// *** power_stage_model.sv ***
// Purpose: Power stages and load seen by the sequencer.
// Assumes: Output tracks target only while the stage is driven.
// Notes: Calibration load adds a fixed 16 codes to every phase.
module power_stage_model
  import seq_pkg::*;
(
  // Clock
  input wire logic mclk_in,
  // From the sequencer
  input wire logic stage_oe_in,
  input wire logic [7:0] target_in,
  input wire logic cal_load_in,
  // To the sequencer
  output logic [7:0] vadc_out,
  output logic [CUR_BITS-1:0] cur_code_out,
  output logic [7:0] loop_width_out
);
  // Released stage lets the output collapse; no width is offered then
  always_ff @(posedge mclk_in)
  begin
    vadc_out <= stage_oe_in ? target_in : 8'h00;
    loop_width_out <= stage_oe_in ? 8'h30 : 8'h00;
    cur_code_out <= cal_load_in ? 6'h18 : 6'h08;
  end
endmodule : power_stage_model

// *** testbench.sv ***
// Purpose: Self-checking bench for the regulator sequencer.
// Assumes: Config store answers one cycle after its address.
// Notes: Restart hold-off shortened to 20 cycles.
module testbench
  import seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic w; logic [3:0] a; logic [15:0] d; logic [15:0] e;} row_type;
  logic mclk_in, reset_in, ext_rst_n_in, wr_in, rd_in, regulator_enable_in, code_valid_in;
  logic supply_ok_in, stage_oe_out, stage_level_out, output_good_flag_out, good_oe_out;
  logic sample_tick_out, cal_load_out;
  logic [3:0] addr_in, fault_in;
  logic [15:0] wdata_in, rdata_out, rv, config_store_data_in;
  logic [2:0] config_store_addr_out, state_out, cur_sel_out;
  logic [7:0] voltage_code_in, vadc_in, loop_width_in, width_out, target_out, cal_current_out;
  logic [5:0] cur_code_in;
  logic [1:0] sense_mode_out;
  int errors = 0;
  int check_count = 0;
  int n;
  logic [15:0] store [5] = '{16'h0001, 16'h0106, 16'h0000, 16'h2020, 16'h000F};
  row_type rows [9] = '{
    '{1'b0, 4'h0, 16'h0, 16'h0001}, '{1'b0, 4'h1, 16'h0, 16'h0106},
    '{1'b0, 4'h2, 16'h0, 16'h0000}, '{1'b0, 4'h3, 16'h0, 16'h2020},
    '{1'b0, 4'h4, 16'h0, 16'h000F}, '{1'b0, 4'h5, 16'h0, 16'h0001},
    '{1'b1, 4'h5, 16'h00FF, 16'h0001}, '{1'b1, 4'hF, 16'h1234, 16'h0000},
    '{1'b1, 4'h3, 16'h1010, 16'h1010}};
  logic [15:0] dv [3] = '{16'h0001, 16'h00A9, 16'h0151};
  logic [5:0] de [3] = '{6'h0A, 6'h1F, 6'h20};

  reg_sequencer #(.RESTART_CYCLES(20)) i_reg_sequencer (.mclk_in(mclk_in),
    .reset_in(reset_in), .ext_rst_n_in(ext_rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .config_store_addr_out(config_store_addr_out), .config_store_data_in(config_store_data_in),
    .regulator_enable_in(regulator_enable_in), .voltage_code_in(voltage_code_in),
    .code_valid_in(code_valid_in), .supply_ok_in(supply_ok_in), .fault_in(fault_in),
    .vadc_in(vadc_in), .cur_code_in(cur_code_in), .loop_width_in(loop_width_in),
    .stage_oe_out(stage_oe_out), .stage_level_out(stage_level_out), .width_out(width_out),
    .target_out(target_out), .output_good_flag_out(output_good_flag_out),
    .good_oe_out(good_oe_out), .state_out(state_out), .sample_tick_out(sample_tick_out),
    .cur_sel_out(cur_sel_out), .sense_mode_out(sense_mode_out), .cal_load_out(cal_load_out),
    .cal_current_out(cal_current_out));
  power_stage_model i_power_stage_model (.mclk_in(mclk_in), .stage_oe_in(stage_oe_out),
    .target_in(target_out), .cal_load_in(cal_load_out), .vadc_out(vadc_in),
    .cur_code_out(cur_code_in), .loop_width_out(loop_width_in));

  // Out-of-range store address returns a changing pattern, not a stale word
  always_ff @(posedge mclk_in)
    config_store_data_in <= (config_store_addr_out < 3'h5) ? store[config_store_addr_out] : ~rv;

  initial
  begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_in);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    @(negedge mclk_in);
    rv = rdata_out;
  endtask : rd

  task automatic wait_state(input logic [2:0] s, input int lim);
    int k;
    k = 0;
    @(negedge mclk_in);
    while (state_out !== s && k < lim)
    begin
      @(negedge mclk_in);
      k++;
    end
    check({13'h0, state_out}, {13'h0, s});
  endtask : wait_state

  task automatic set_enable(input logic v);
    @(posedge mclk_in);
    regulator_enable_in <= v;
  endtask : set_enable

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (40000) @(posedge mclk_in);
    errors++;
    test_done();
  end

  initial
  begin
    {wr_in, rd_in, regulator_enable_in, code_valid_in, supply_ok_in} = 5'h00;
    reset_in = 1'b1;
    ext_rst_n_in = 1'b1;
    addr_in = 4'h0;
    wdata_in = 16'h0000;
    fault_in = 4'h0;
    voltage_code_in = 8'h40;
    rv = 16'h0000;
    cyc(4);
    reset_in <= 1'b0;
    @(negedge mclk_in);
    check({14'h0, stage_oe_out, good_oe_out}, 16'h0);
    wait_state(3'h1, 10);
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      check(rv, rows[i].e);
    end
    wr(4'h4, 16'h0001);
    for (int i = 0; i < 3; i++)
    begin
      wr(4'h0, dv[i]);
      cyc(3);
      check({10'h0, sense_mode_out, stage_oe_out, stage_oe_out & stage_level_out, good_oe_out,
        good_oe_out & output_good_flag_out}, {10'h0, de[i]});
    end
    wr(4'h0, 16'h0001);
    @(posedge mclk_in);
    {regulator_enable_in, code_valid_in} <= 2'h3;
    cyc(10);
    check({13'h0, state_out}, 16'h0001);
    @(posedge mclk_in);
    supply_ok_in <= 1'b1;
    wait_state(3'h2, 3);
    wait_state(3'h4, 300);
    check({8'h0, target_out}, 16'h0040);
    check({7'h0, output_good_flag_out, width_out}, 16'h0130);
    n = 0;
    repeat (60)
    begin
      @(negedge mclk_in);
      n += sample_tick_out;
    end
    check(n[15:0], 16'h000A);
    rd(4'h7);
    check(rv, 16'h0100);
    set_enable(1'b0);
    wait_state(3'h5, 3);
    wait_state(3'h6, 200);
    check({7'h0, stage_oe_out, width_out}, 16'h0);
    wait_state(3'h1, 30);
    cyc(20);
    set_enable(1'b1);
    wait_state(3'h4, 300);
    @(posedge mclk_in);
    voltage_code_in <= 8'hFF;
    wait_state(3'h5, 3);
    @(posedge mclk_in);
    voltage_code_in <= 8'h40;
    wait_state(3'h4, 400);
    wr(4'h0, 16'h0005);
    @(posedge mclk_in);
    fault_in <= 4'h1;
    wait_state(3'h5, 3);
    @(posedge mclk_in);
    fault_in <= 4'h0;
    wait_state(3'h1, 300);
    cyc(30);
    check({13'h0, state_out}, 16'h0001);
    rd(4'h5);
    check(rv, 16'h0011);
    rd(4'h6);
    check(rv, 16'h0001);
    wr(4'h6, 16'h0001);
    rd(4'h6);
    check(rv, 16'h0000);
    set_enable(1'b0);
    cyc(2);
    set_enable(1'b1);
    wait_state(3'h4, 300);
    wr(4'h0, 16'h0002);
    // Lockout off: a dead supply comparator must not block the start
    supply_ok_in <= 1'b0;
    set_enable(1'b0);
    wait_state(3'h1, 300);
    set_enable(1'b1);
    wait_state(3'h3, 300);
    check({8'h0, cal_current_out}, 16'h0010);
    repeat (600) @(negedge mclk_in);
    check({4'h0, cal_load_out, cur_sel_out, cal_current_out}, 16'h0810);
    wait_state(3'h4, 8000);
    rd(4'h9);
    check(rv, 16'h0408);
    @(posedge mclk_in);
    ext_rst_n_in <= 1'b0;
    @(negedge mclk_in);
    check({13'h0, state_out}, 16'h0000);
    check({14'h0, stage_oe_out, good_oe_out}, 16'h0);
    @(posedge mclk_in);
    ext_rst_n_in <= 1'b1;
    wait_state(3'h1, 10);
    rd(4'h0);
    check(rv, 16'h0001);
    test_done();
  end
endmodule : testbench
